//--- src/ilcs_command_slave.sv
`timescale 1ns/1ps
module ilcs_command_slave import ilcs_pkg::*; (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output wire logic       sda_out,
  output wire logic       sda_oe,
  input  wire logic       address_select_pin,
  input  wire logic       hw_subaddr_bit_low_pin,
  input  wire logic       hw_subaddr_bit_high_pin,
  input  wire logic       osc_clk_in,
  output wire logic       clk_out,
  output wire logic       display_enable,
  output wire logic       bias_half,
  output wire logic [1:0] drive_mode,
  output wire logic [7:0] data_pointer,
  output wire logic [1:0] subaddr_counter,
  output wire logic       input_bank,
  output wire logic       output_bank,
  output wire logic       alt_bank_blink_bit,
  output wire logic [1:0] blink_rate_field,
  output wire logic [2:0] frame_rate,
  output wire logic       ram_wr_en,
  output wire logic [7:0] ram_wr_addr,
  output wire logic [7:0] ram_wr_data,
  output wire logic       ram_wr_bank
);
  ilcs_link_if lnk ();

  ilcs_bit_rx u_rx (
    .clk     (clk),
    .nrst    (nrst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .lnk     (lnk.rx)
  );

  ////////////////////////////////////////////////////////////////////////
  // Straps and the oscillator are pins: two flops before any use
  logic [3:0] strap_meta_ff, nxt_strap_meta;
  logic [3:0] strap_ff;

  always_comb begin
    nxt_strap_meta = {osc_clk_in, hw_subaddr_bit_high_pin,
                      hw_subaddr_bit_low_pin, address_select_pin};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_meta_ff <= 4'h0;
      strap_ff      <= 4'h0;
    end else begin
      strap_meta_ff <= nxt_strap_meta;
      strap_ff      <= strap_meta_ff;
    end
  end

  logic       sa_level;
  logic [1:0] hw_subaddr;
  logic       osc_s;
  assign sa_level   = strap_ff[0];
  assign hw_subaddr = strap_ff[2:1];
  assign osc_s      = strap_ff[3];

  ////////////////////////////////////////////////////////////////////////
  // Transfer state and settings
  ilcs_state_t state_ff, nxt_state;
  logic       tgt_ff, nxt_tgt;
  logic       ack_ff, nxt_ack;
  logic       en_ff, nxt_en;
  logic       bias_ff, nxt_bias;
  logic [1:0] mode_ff, nxt_mode;
  logic [7:0] ptr_ff, nxt_ptr;
  logic [1:0] sub_ff, nxt_sub;
  logic       ibank_ff, nxt_ibank;
  logic       obank_ff, nxt_obank;
  logic       alt_ff, nxt_alt;
  logic [1:0] blink_ff, nxt_blink;
  logic [2:0] frame_ff, nxt_frame;
  logic       wr_ff, nxt_wr;
  logic [7:0] waddr_ff, nxt_waddr;
  logic [7:0] wdata_ff, nxt_wdata;
  logic       wbank_ff, nxt_wbank;
  logic       clko_ff, nxt_clko;

  logic [7:0] b;
  logic       addr_hit, sub_hit, mux34, wrap, in_payload;
  logic [8:0] inc, ptr_sum;

  assign b = lnk.byte_data;
  // Bit 1 against the strap, bit 0 must be write
  assign addr_hit = (b[7:2] == ILCS_ADDR_PREFIX) && (b[1] == sa_level)
                    && !b[0];
  assign sub_hit    = (sub_ff == hw_subaddr);
  assign mux34      = (mode_ff == ILCS_MODE_MUX3) ||
                      (mode_ff == ILCS_MODE_MUX4);
  assign in_payload = (state_ff == st_once) || (state_ff == st_stream);

  // Pointer step per display byte follows the backplane count
  always_comb begin
    unique case (mode_ff)
      ILCS_MODE_STATIC: inc = ILCS_INC_STATIC;
      ILCS_MODE_MUX2:   inc = ILCS_INC_MUX2;
      ILCS_MODE_MUX3:   inc = ILCS_INC_MUX3;
      ILCS_MODE_MUX4:   inc = ILCS_INC_MUX4;
    endcase
  end

  assign ptr_sum = {1'b0, ptr_ff} + inc;
  assign wrap    = (ptr_sum >= ILCS_RAM_DEPTH);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    nxt_tgt   = tgt_ff;
    nxt_ack   = ack_ff;
    nxt_en    = en_ff;
    nxt_bias  = bias_ff;
    nxt_mode  = mode_ff;
    nxt_ptr   = ptr_ff;
    nxt_sub   = sub_ff;
    nxt_ibank = ibank_ff;
    nxt_obank = obank_ff;
    nxt_alt   = alt_ff;
    nxt_blink = blink_ff;
    nxt_frame = frame_ff;
    nxt_wr    = 1'b0;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wbank = wbank_ff;
    nxt_clko  = osc_s & en_ff;
    if (lnk.stop_det) begin
      nxt_state = st_idle;
      nxt_ack   = 1'b0;
    end else if (lnk.start_det) begin
      nxt_state = st_addr;
      nxt_ack   = 1'b0;
    end else if (lnk.byte_valid) begin
      nxt_ack = 1'b0;
      unique case (state_ff)
        st_idle, st_ignore: begin
          // Not addressed: no ack until the next start or stop
        end
        st_addr: begin
          if (addr_hit) begin
            nxt_state = st_ctrl;
            nxt_ack   = 1'b1;
          end else begin
            nxt_state = st_ignore;
          end
        end
        st_ctrl: begin
          nxt_ack   = 1'b1;
          nxt_tgt   = b[ILCS_CTRL_TGT_BIT];
          nxt_state = b[ILCS_CTRL_MORE_BIT] ? st_once : st_stream;
        end
        st_once, st_stream: begin
          if (state_ff == st_once) begin
            nxt_state = st_ctrl;
          end
          if (tgt_ff) begin
            // All devices track pointer and counter, only one stores
            nxt_ack   = sub_hit;
            nxt_wr    = sub_hit;
            nxt_waddr = ptr_ff;
            nxt_wdata = b;
            nxt_wbank = ibank_ff;
            if (wrap) begin
              nxt_ptr = 8'(ptr_sum - ILCS_RAM_DEPTH);
              nxt_sub = 2'(sub_ff + 2'h1);
            end else begin
              nxt_ptr = ptr_sum[7:0];
            end
          end else begin
            nxt_ack = 1'b1;
            if (b[7:4] == ILCS_OP_MODE_SET) begin
              nxt_en   = b[3];
              nxt_bias = b[2];
              nxt_mode = b[1:0];
            end else if (b[7:4] == ILCS_OP_PTR_HI) begin
              nxt_ptr = {b[3:0], ptr_ff[3:0]};
            end else if (b[7:4] == ILCS_OP_PTR_LO) begin
              nxt_ptr = {ptr_ff[7:4], b[3:0]};
            end else if (b[7:2] == ILCS_OP_DEV_SEL) begin
              nxt_sub = b[1:0];
            end else if (b[7:2] == ILCS_OP_BANK_SEL) begin
              if (!mux34) begin
                nxt_ibank = b[1];
                nxt_obank = b[0];
              end
            end else if (b[7:3] == ILCS_OP_BLINK) begin
              nxt_alt   = b[2];
              nxt_blink = b[1:0];
            end else if (b[7:3] == ILCS_OP_FRAME) begin
              nxt_frame = b[2:0];
            end
            // Anything else is acked and dropped
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= st_idle;
      tgt_ff   <= ILCS_RST_BIT;
      ack_ff   <= ILCS_RST_BIT;
      en_ff    <= ILCS_RST_BIT;
      bias_ff  <= ILCS_RST_BIT;
      mode_ff  <= ILCS_RST_MODE;
      ptr_ff   <= ILCS_RST_PTR;
      sub_ff   <= ILCS_RST_SUBADDR;
      ibank_ff <= ILCS_RST_BIT;
      obank_ff <= ILCS_RST_BIT;
      alt_ff   <= ILCS_RST_BIT;
      blink_ff <= ILCS_RST_BLINK;
      frame_ff <= ILCS_RST_FRAME;
      wr_ff    <= ILCS_RST_BIT;
      waddr_ff <= ILCS_RST_PTR;
      wdata_ff <= ILCS_RST_BYTE;
      wbank_ff <= ILCS_RST_BIT;
      clko_ff  <= ILCS_RST_BIT;
    end else begin
      state_ff <= nxt_state;
      tgt_ff   <= nxt_tgt;
      ack_ff   <= nxt_ack;
      en_ff    <= nxt_en;
      bias_ff  <= nxt_bias;
      mode_ff  <= nxt_mode;
      ptr_ff   <= nxt_ptr;
      sub_ff   <= nxt_sub;
      ibank_ff <= nxt_ibank;
      obank_ff <= nxt_obank;
      alt_ff   <= nxt_alt;
      blink_ff <= nxt_blink;
      frame_ff <= nxt_frame;
      wr_ff    <= nxt_wr;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wbank_ff <= nxt_wbank;
      clko_ff  <= nxt_clko;
    end
  end

  assign lnk.ack_want       = ack_ff;
  assign clk_out            = clko_ff;
  assign display_enable     = en_ff;
  assign bias_half          = bias_ff;
  assign drive_mode         = mode_ff;
  assign data_pointer       = ptr_ff;
  assign subaddr_counter    = sub_ff;
  assign input_bank         = ibank_ff;
  assign output_bank        = obank_ff;
  assign alt_bank_blink_bit = alt_ff;
  assign blink_rate_field   = blink_ff;
  assign frame_rate         = frame_ff;
  assign ram_wr_en          = wr_ff;
  assign ram_wr_addr        = waddr_ff;
  assign ram_wr_data        = wdata_ff;
  assign ram_wr_bank        = wbank_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic byte_ok, cmd_byte, known_op;
  assign byte_ok  = lnk.byte_valid && !lnk.start_det && !lnk.stop_det;
  assign cmd_byte = byte_ok && in_payload && !tgt_ff;
  assign known_op = (b[7:4] == ILCS_OP_MODE_SET) ||
                    (b[7:4] == ILCS_OP_PTR_HI) ||
                    (b[7:4] == ILCS_OP_PTR_LO) ||
                    (b[7:2] == ILCS_OP_DEV_SEL) ||
                    (b[7:2] == ILCS_OP_BANK_SEL) ||
                    (b[7:3] == ILCS_OP_BLINK) ||
                    (b[7:3] == ILCS_OP_FRAME);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_addr_ack;
    byte_ok && state_ff == st_addr && addr_hit |=>
      ack_ff && state_ff == st_ctrl;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("matching address not acknowledged");

  property p_addr_miss;
    byte_ok && state_ff == st_addr && !addr_hit |=>
      !ack_ff && state_ff == st_ignore ##1 !ram_wr_en;
  endproperty
  a_addr_miss: assert property (p_addr_miss)
    else $error("foreign or read address not ignored");

  property p_store_match;
    ram_wr_en |-> $past(sub_hit) && ram_wr_addr == $past(ptr_ff);
  endproperty
  a_store_match: assert property (p_store_match)
    else $error("display byte stored by unselected device");

  property p_mode_set;
    cmd_byte && b[7:4] == ILCS_OP_MODE_SET |=>
      en_ff == $past(b[3]) && bias_ff == $past(b[2]) &&
      mode_ff == $past(b[1:0]);
  endproperty
  a_mode_set: assert property (p_mode_set)
    else $error("mode-set not applied");

  property p_bank_lock;
    cmd_byte && b[7:2] == ILCS_OP_BANK_SEL && mux34 |=>
      $stable(ibank_ff) && $stable(obank_ff);
  endproperty
  a_bank_lock: assert property (p_bank_lock)
    else $error("bank select acted in three/four backplane mode");

  property p_ptr_hi;
    cmd_byte && b[7:4] == ILCS_OP_PTR_HI |=>
      ptr_ff == {$past(b[3:0]), $past(ptr_ff[3:0])};
  endproperty
  a_ptr_hi: assert property (p_ptr_hi)
    else $error("pointer high nibble not loaded");

  property p_undefined;
    cmd_byte && !known_op |=> ack_ff && $stable(ptr_ff) &&
      $stable(sub_ff) && $stable(mode_ff) && $stable(frame_ff) &&
      $stable(blink_ff) && $stable(en_ff);
  endproperty
  a_undefined: assert property (p_undefined)
    else $error("undefined command changed a setting");

  property p_wrap;
    byte_ok && in_payload && tgt_ff && wrap |=>
      sub_ff == 2'($past(sub_ff) + 2'h1) && ptr_ff < 8'hA0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer wrap did not advance subaddress");

  property p_clk_gate;
    !en_ff |=> !clk_out;
  endproperty
  a_clk_gate: assert property (p_clk_gate)
    else $error("clock output running while display disabled");

  c_write: cover property (ram_wr_en);
  c_wrap: cover property (byte_ok && in_payload && tgt_ff && wrap);
  c_bank: cover property (cmd_byte && b[7:2] == ILCS_OP_BANK_SEL);
  c_ignore: cover property (state_ff == st_ignore);
endmodule

//--- src/ilcs_pkg.sv
package ilcs_pkg;
  // Slave address: bits 7..2 fixed, bit 1 strapped, bit 0 write only
  localparam logic [5:0] ILCS_ADDR_PREFIX   = 6'h1C;
  // Control byte bit positions
  localparam int         ILCS_CTRL_MORE_BIT = 7;
  localparam int         ILCS_CTRL_TGT_BIT  = 6;
  // Command opcodes
  localparam logic [3:0] ILCS_OP_MODE_SET   = 4'hC;
  localparam logic [3:0] ILCS_OP_PTR_HI     = 4'h0;
  localparam logic [3:0] ILCS_OP_PTR_LO     = 4'h4;
  localparam logic [5:0] ILCS_OP_DEV_SEL    = 6'h38;
  localparam logic [5:0] ILCS_OP_BANK_SEL   = 6'h3E;
  localparam logic [4:0] ILCS_OP_BLINK      = 5'h1E;
  localparam logic [4:0] ILCS_OP_FRAME      = 5'h1D;
  // Drive mode encodings
  localparam logic [1:0] ILCS_MODE_STATIC   = 2'h1;
  localparam logic [1:0] ILCS_MODE_MUX2     = 2'h2;
  localparam logic [1:0] ILCS_MODE_MUX3     = 2'h3;
  localparam logic [1:0] ILCS_MODE_MUX4     = 2'h0;
  // Values after reset
  localparam logic       ILCS_RST_BIT       = 1'h0;
  localparam logic [1:0] ILCS_RST_MODE      = 2'h0;
  localparam logic [7:0] ILCS_RST_PTR       = 8'h00;
  localparam logic [1:0] ILCS_RST_SUBADDR   = 2'h0;
  localparam logic [1:0] ILCS_RST_BLINK     = 2'h0;
  localparam logic [2:0] ILCS_RST_FRAME     = 3'h3;
  localparam logic [7:0] ILCS_RST_BYTE      = 8'h00;
  // Display RAM size and pointer advance per display byte
  localparam logic [8:0] ILCS_RAM_DEPTH     = 9'h0A0;
  localparam logic [8:0] ILCS_INC_STATIC    = 9'h008;
  localparam logic [8:0] ILCS_INC_MUX2      = 9'h004;
  localparam logic [8:0] ILCS_INC_MUX3      = 9'h003;
  localparam logic [8:0] ILCS_INC_MUX4      = 9'h002;
  // Serial byte framing
  localparam logic [3:0] ILCS_BITCNT_ZERO   = 4'h0;
  localparam logic [3:0] ILCS_BITCNT_FULL   = 4'h8;

  typedef enum logic [2:0] {
    st_idle, st_addr, st_ctrl, st_once, st_stream, st_ignore
  } ilcs_state_t;
endpackage

//--- src/ilcs_link_if.sv
`timescale 1ns/1ps
interface ilcs_link_if;
  logic       start_det;
  logic       stop_det;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       ack_want;

  modport rx (
    output start_det,
    output stop_det,
    output byte_valid,
    output byte_data,
    input  ack_want
  );
  modport dec (
    input  start_det,
    input  stop_det,
    input  byte_valid,
    input  byte_data,
    output ack_want
  );
endinterface

//--- src/ilcs_bit_rx.sv
`timescale 1ns/1ps
module ilcs_bit_rx import ilcs_pkg::*; (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output wire logic sda_out,
  output wire logic sda_oe,
  ilcs_link_if.rx   lnk
);
  logic [1:0] meta_ff;
  logic [1:0] sync_ff;
  logic [1:0] prev_ff;
  logic [7:0] shift_ff, nxt_shift;
  logic [3:0] bitcnt_ff, nxt_bitcnt;
  logic       ackclk_ff, nxt_ackclk;
  logic       oe_ff, nxt_oe;
  logic       bv_ff, nxt_bv;
  logic       sta_ff, sto_ff;
  logic       rise, fall, sta, sto;

  ////////////////////////////////////////////////////////////////////////
  // Two-flop sync; edges come from the second stage only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= 2'h3;
      sync_ff <= 2'h3;
      prev_ff <= 2'h3;
    end else begin
      meta_ff <= {scl_in, sda_in};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign rise = sync_ff[1] & ~prev_ff[1];
  assign fall = ~sync_ff[1] & prev_ff[1];
  assign sta  = sync_ff[1] & prev_ff[1] & prev_ff[0] & ~sync_ff[0];
  assign sto  = sync_ff[1] & prev_ff[1] & ~prev_ff[0] & sync_ff[0];

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_shift  = shift_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_ackclk = ackclk_ff;
    nxt_oe     = oe_ff;
    nxt_bv     = 1'b0;
    if (sta || sto) begin
      // Partial byte dropped on a frame condition
      nxt_bitcnt = ILCS_BITCNT_ZERO;
      nxt_ackclk = 1'b0;
      nxt_oe     = 1'b0;
    end else if (rise) begin
      if (bitcnt_ff != ILCS_BITCNT_FULL) begin
        nxt_shift  = {shift_ff[6:0], sync_ff[0]};
        nxt_bitcnt = bitcnt_ff + 4'h1;
        nxt_bv     = (bitcnt_ff == ILCS_BITCNT_FULL - 4'h1);
      end else begin
        nxt_ackclk = 1'b1;
      end
    end else if (fall && bitcnt_ff == ILCS_BITCNT_FULL) begin
      if (!ackclk_ff) begin
        nxt_oe = lnk.ack_want;
      end else begin
        nxt_oe     = 1'b0;
        nxt_ackclk = 1'b0;
        nxt_bitcnt = ILCS_BITCNT_ZERO;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_ff  <= ILCS_RST_BYTE;
      bitcnt_ff <= ILCS_BITCNT_ZERO;
      ackclk_ff <= 1'b0;
      oe_ff     <= 1'b0;
      bv_ff     <= 1'b0;
      sta_ff    <= 1'b0;
      sto_ff    <= 1'b0;
    end else begin
      shift_ff  <= nxt_shift;
      bitcnt_ff <= nxt_bitcnt;
      ackclk_ff <= nxt_ackclk;
      oe_ff     <= nxt_oe;
      bv_ff     <= nxt_bv;
      sta_ff    <= sta;
      sto_ff    <= sto;
    end
  end

  // Open drain: only ever pulls low, never sends data
  assign sda_out        = 1'b0;
  assign sda_oe         = oe_ff;
  assign lnk.byte_valid = bv_ff;
  assign lnk.byte_data  = shift_ff;
  assign lnk.start_det  = sta_ff;
  assign lnk.stop_det   = sto_ff;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_byte_full;
    lnk.byte_valid |-> bitcnt_ff == ILCS_BITCNT_FULL && !ackclk_ff;
  endproperty
  a_byte_full: assert property (p_byte_full)
    else $error("byte delivered before eight bits");

  property p_oe_in_ack;
    sda_oe |-> bitcnt_ff == ILCS_BITCNT_FULL;
  endproperty
  a_oe_in_ack: assert property (p_oe_in_ack)
    else $error("data line driven outside acknowledge slot");

  property p_ack_drive;
    fall && !sta && !sto && bitcnt_ff == ILCS_BITCNT_FULL && !ackclk_ff
      && lnk.ack_want |=> sda_oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("requested acknowledge not driven");

  property p_frame_clear;
    (sta || sto) |=> bitcnt_ff == ILCS_BITCNT_ZERO && !sda_oe &&
      (lnk.start_det || lnk.stop_det);
  endproperty
  a_frame_clear: assert property (p_frame_clear)
    else $error("start or stop did not clear the receiver");

  c_ack: cover property (fall && ackclk_ff && sda_oe);
endmodule

//--- verification/ilcs_bus_master.sv
`timescale 1ns/1ps
module ilcs_bus_master (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl_pin,
  output logic      sda_drv
);
  // Both lines idle high through the pull-ups
  initial begin
    scl_pin = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Start, or repeated start from SCL low; leaves SCL low
  task automatic start_cond();
    tick(2);
    sda_drv <= 1'b1;
    tick(2);
    scl_pin <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl_pin <= 1'b0;
  endtask
  task automatic stop_cond();
    tick(2);
    sda_drv <= 1'b0;
    tick(2);
    scl_pin <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask
  // Data moves mid low phase so it never changes while SCL is high
  task automatic clock_bit(input logic b, output logic seen);
    tick(2);
    sda_drv <= b;
    tick(2);
    scl_pin <= 1'b1;
    tick(3);
    seen = sda_line;
    tick(1);
    scl_pin <= 1'b0;
  endtask
  // Ninth clock releases SDA; a low level there is the acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clock_bit(b[i], s);
    clock_bit(1'b1, s);
    ack = ~s;
  endtask
endmodule

//--- verification/ilcs_command_slave_test.sv
`timescale 1ns/1ps
module ilcs_command_slave_test import ilcs_pkg::*; ;
  localparam logic [7:0] BAD [3] = '{8'h71, 8'h72, 8'h30};
  logic            clk, nrst, sa_pin, sub_lo, sub_hi, osc;
  wire logic       scl, sda_m, sda_out, sda_oe, sda_line, clk_out;
  wire logic       display_enable, bias_half, input_bank, output_bank;
  wire logic       alt_bank_blink_bit, ram_wr_en, ram_wr_bank;
  wire logic [1:0] drive_mode, subaddr_counter, blink_rate_field;
  wire logic [2:0] frame_rate;
  wire logic [3:0] mode_word;
  wire logic [7:0] data_pointer, ram_wr_addr, ram_wr_data;
  int              mismatches, checks_done, wr_count;
  ////////////////////////////////////////////////////////////////////////////
  // Open-drain wire: pulled up, low if either party pulls
  assign sda_line = sda_m & ~(sda_oe & ~sda_out);
  assign mode_word = {display_enable, bias_half, drive_mode};
  always #10 clk = ~clk;
  // Single driver for the write counter, cleared by reset
  always @(posedge clk)
    if (!nrst)
      wr_count <= 0;
    else if (ram_wr_en === 1'b1)
      wr_count <= wr_count + 1;
  ilcs_bus_master ilcs_bus_master_i (
    .clk(clk), .sda_line(sda_line), .scl_pin(scl), .sda_drv(sda_m)
  );
  ilcs_command_slave ilcs_command_slave_i (
    .clk, .nrst, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
    .address_select_pin(sa_pin), .hw_subaddr_bit_low_pin(sub_lo),
    .hw_subaddr_bit_high_pin(sub_hi), .osc_clk_in(osc), .clk_out,
    .display_enable, .bias_half, .drive_mode, .data_pointer,
    .subaddr_counter, .input_bank, .output_bank, .alt_bank_blink_bit,
    .blink_rate_field, .frame_rate, .ram_wr_en, .ram_wr_addr,
    .ram_wr_data, .ram_wr_bank
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic exp);
    logic ack;
    ilcs_bus_master_i.put_byte(b, ack);
    chk("ack", {7'h00, exp}, {7'h00, ack});
  endtask
  // Start, own address, one control byte
  task automatic open_xfer(input logic [7:0] ctrl);
    ilcs_bus_master_i.start_cond();
    send(8'h70, 1'b1);
    send(ctrl, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    sa_pin = 1'b0;
    sub_lo = 1'b0;
    sub_hi = 1'b0;
    osc = 1'b1;
    mismatches = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    chk("idle sda", 8'h00, 8'({sda_oe, sda_out}));
    chk("clk_out", 8'h00, 8'(clk_out));
    chk("mode set", 8'h00, 8'(mode_word));
    chk("pointer", 8'h00, data_pointer);
    chk("subaddr", 8'h00, 8'(subaddr_counter));
    chk("banks", 8'h00, 8'({input_bank, output_bank}));
    chk("blink", 8'h00, 8'({alt_bank_blink_bit, blink_rate_field}));
    chk("frame", {5'h00, ILCS_RST_FRAME}, 8'(frame_rate));
    // Foreign, read and wrong-select addresses: whole transfer ignored
    foreach (BAD[k]) begin
      ilcs_bus_master_i.start_cond();
      send(BAD[k], 1'b0);
      send(8'h70, 1'b0);
      send(8'h00, 1'b0);
      send(8'hCF, 1'b0);
      ilcs_bus_master_i.stop_cond();
    end
    chk("ignored", 8'h00, 8'({display_enable, drive_mode}));
    // 0x0F must be a control byte; as a command it would move the pointer
    open_xfer(8'h80);
    send(8'hC9, 1'b1);
    send(8'h0F, 1'b1);
    send(8'hFA, 1'b1);
    send(8'hF7, 1'b1);
    send(8'hE8, 1'b1);
    send(8'hE2, 1'b1);
    send(8'h4E, 1'b1);
    send(8'h23, 1'b1);
    ilcs_bus_master_i.stop_cond();
    chk("mode set", 8'h09, 8'(mode_word));
    chk("clk_out", 8'h01, 8'(clk_out));
    // Gate must pass the clock itself, not a constant enable copy
    osc <= 1'b0;
    repeat (4) @(posedge clk);
    chk("clk_out", 8'h00, 8'(clk_out));
    osc <= 1'b1;
    chk("pointer", 8'h0E, data_pointer);
    chk("subaddr", 8'h02, 8'(subaddr_counter));
    chk("banks", 8'h02, 8'({input_bank, output_bank}));
    chk("blink", 8'h07, 8'({alt_bank_blink_bit, blink_rate_field}));
    chk("frame", 8'h00, 8'(frame_rate));
    for (int m = 0; m < 4; m++) begin
      open_xfer(8'h00);
      send(8'hC0 | 8'(m), 1'b1);
      ilcs_bus_master_i.stop_cond();
      chk("drive mode", 8'(m), 8'(drive_mode));
    end
    // Three-backplane mode: bank select acked but ignored
    open_xfer(8'h00);
    send(8'hF9, 1'b1);
    ilcs_bus_master_i.stop_cond();
    chk("banks", 8'h02, 8'({input_bank, output_bank}));
    // Strap 1: first byte belongs to device 0, then wrap into device 1
    sub_lo <= 1'b1;
    open_xfer(8'h00);
    send(8'hC5, 1'b1);
    send(8'hE0, 1'b1);
    send(8'h09, 1'b1);
    send(8'h4E, 1'b1);
    ilcs_bus_master_i.start_cond();
    send(8'h70, 1'b1);
    send(8'h40, 1'b1);
    send(8'hAB, 1'b0);
    send(8'hCD, 1'b1);
    ilcs_bus_master_i.stop_cond();
    chk("writes", 8'h01, 8'(wr_count));
    chk("wr addr", 8'h06, ram_wr_addr);
    chk("wr data", 8'hCD, ram_wr_data);
    chk("wr bank", 8'h01, 8'(ram_wr_bank));
    chk("pointer", 8'h0E, data_pointer);
    chk("subaddr", 8'h01, 8'(subaddr_counter));
    // Select strap high: only the bit-1 address answers
    sa_pin <= 1'b1;
    repeat (4) @(posedge clk);
    ilcs_bus_master_i.start_cond();
    send(8'h70, 1'b0);
    ilcs_bus_master_i.start_cond();
    send(8'h72, 1'b1);
    send(8'h80, 1'b1);
    send(8'hC8, 1'b1);
    // Four-backplane display byte: pointer steps by two
    send(8'h40, 1'b1);
    send(8'h11, 1'b1);
    ilcs_bus_master_i.stop_cond();
    chk("enable", 8'h06, 8'({display_enable, clk_out, sda_oe}));
    chk("wr addr", 8'h0E, ram_wr_addr);
    chk("pointer", 8'h10, data_pointer);
    wrap_up();
  end
endmodule
